//--- rtl/txd_crc32.v
// Byte-wide reflected CRC-32 accumulator with a registered result
`include "txd_defines.vh"

module txd_crc32 (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire init_i,
    input wire en_i,
    input wire [7:0] data_i,
    output reg [31:0] crc_o
);

reg [31:0] crc_next;
integer i;

////////////////////////////////////////////////////////////////////////////////
// One byte, LSB first, eight serial steps unrolled by the loop
always @* begin
    crc_next = crc_o ^ {24'h00_0000, data_i};
    for (i = 0; i < 8; i = i + 1) begin
        crc_next = crc_next[0] ? ((crc_next >> 1) ^ `TXD_CRC_POLY) : (crc_next >> 1);
    end
end

// Init has priority so a new packet never inherits a stale remainder
always @(posedge clk_i) begin
    if (rst_i) begin
        crc_o <= `TXD_CRC_INIT;
    end else if (ce_i) begin
        if (init_i) begin
            crc_o <= `TXD_CRC_INIT;
        end else if (en_i) begin
            crc_o <= crc_next;
        end
    end
end

endmodule // txd_crc32

//--- rtl/txd_defines.vh
// Constants for the transmit descriptor engine: register map, descriptor layout, flags
`ifndef TXD_DEFINES_VH
`define TXD_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the Wishbone slave
`define TXD_OFS_HEAD 8'h00
`define TXD_OFS_ACK 8'h04
`define TXD_OFS_CTRL 8'h08
`define TXD_OFS_STAT 8'h0C

////////////////////////////////////////////////////////////////////////////////
// Descriptor word byte offsets from the descriptor base
`define TXD_W_LINK 4'h0
`define TXD_W_BPTR 4'h4
`define TXD_W_OFSLEN 4'h8
`define TXD_W_FLGLEN 4'hC

// Flag bit positions in the flags/packet-length word
`define TXD_F_FIRST 31
`define TXD_F_LAST 30
`define TXD_F_OWN 29
`define TXD_F_QEND 28
`define TXD_F_TDN 27
`define TXD_F_CRCSUP 26

// Control and status bit positions
`define TXD_CTRL_TDN 0
`define TXD_ST_BUSY 0
`define TXD_ST_QEND 1
`define TXD_ST_TDN 2
`define TXD_ST_NOWN 3
`define TXD_ST_INT 4

// Reset values and counts
`define TXD_RST_WORD 32'h0000_0000
`define TXD_CRC_INIT 32'hFFFF_FFFF
`define TXD_CRC_POLY 32'hEDB8_8320
`define TXD_CRC_BYTES 2'h3

`endif

//--- rtl/txd_engine.v
// Transmit descriptor walker: Wishbone registers, memory master, byte stream to the MAC
//
// Function
// - Descriptor is four aligned 32-bit words
// - Zero link ends queue; link never written
// - Null link already read halts channel
// - Skip offset bytes before buffer data
// - Offset honoured on first fragment only
// - Buffer length counts fetched data bytes
// - Packet length taken from first fragment
// - First flag starts, last flag ends packet
// - Clear ownership in first descriptor after packet
// - Last with null link: set queue end, halt
// - Teardown marks first unsent packet, stops
// - Append generated CRC when not supplied
// - Supplied CRC sent as data, none generated
// - Only ownership, queue-end, teardown flags written
// - Buffer pointer may be any byte address
// - Offset high, length low; flags high, packet low
// - Head pointer write starts or restarts queue
// - Ack register: last done descriptor, interrupt
`include "txd_defines.vh"

module txd_engine (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // Wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // System memory master, word wide
    output reg mem_req_o,
    output reg mem_we_o,
    output reg [31:0] mem_addr_o,
    output reg [31:0] mem_wdata_o,
    input wire [31:0] mem_rdata_i,
    input wire mem_ack_i,
    // Byte stream to the MAC transmit datapath
    output reg [7:0] tx_data_o,
    output reg tx_valid_o,
    output reg tx_first_o,
    output reg tx_last_o,
    input wire tx_ready_i,
    output reg chan_int_o
);

localparam [7:0] S_IDLE = 8'h01;
localparam [7:0] S_DRD = 8'h02;
localparam [7:0] S_BRD = 8'h04;
localparam [7:0] S_BOUT = 8'h08;
localparam [7:0] S_COUT = 8'h10;
localparam [7:0] S_QEND = 8'h20;
localparam [7:0] S_OWN = 8'h40;
localparam [7:0] S_TDN = 8'h80;

reg [7:0] state_reg;
reg [31:0] cur_reg;
reg [31:0] link_reg;
reg [31:0] bptr_reg;
reg [31:0] ofslen_reg;
reg [31:0] flglen_reg;
reg [1:0] widx_reg;
reg [15:0] idx_reg;
reg [15:0] skip_reg;
reg [15:0] pkt_rem_reg;
reg [31:0] sop_addr_reg;
reg [31:0] sop_w3_reg;
reg crc_sup_reg;
reg in_pkt_reg;
reg halt_after_reg;
reg [1:0] cidx_reg;
reg [31:0] done_reg;
reg [31:0] sw_ack_reg;
reg tdn_pend_reg;
reg st_qend_reg;
reg st_tdn_reg;
reg st_nown_reg;
reg crc_init_reg;

wire [31:0] crc_val;
wire [31:0] sel_mask;
wire [31:0] byte_addr;
wire [15:0] buf_len;
wire frag_end;
wire busy;
wire wb_hit;
wire crc_en;

////////////////////////////////////////////////////////////////////////////////
// Field decode and derived terms
assign buf_len = ofslen_reg[15:0];
assign byte_addr = bptr_reg + {16'h0000, skip_reg} + {16'h0000, idx_reg};
assign frag_end = (idx_reg + 16'h0001) == buf_len;
assign busy = (state_reg != S_IDLE);
assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
assign sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
// Only bytes the MAC actually took enter the remainder
assign crc_en = (state_reg == S_BOUT) & tx_valid_o & tx_ready_i & ~crc_sup_reg;

txd_crc32 u_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .init_i(crc_init_reg),
    .en_i(crc_en),
    .data_i(tx_data_o),
    .crc_o(crc_val)
);

////////////////////////////////////////////////////////////////////////////////
// Wishbone slave: one wait state, ack drops the cycle after it is given
always @(posedge clk_i) begin
    if (rst_i) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= `TXD_RST_WORD;
        sw_ack_reg <= `TXD_RST_WORD;
        chan_int_o <= 1'b0;
    end else if (ce_i) begin
        wb_ack_o <= wb_hit;
        chan_int_o <= (done_reg != sw_ack_reg);
        if (wb_hit & wb_we_i & (wb_adr_i == `TXD_OFS_ACK)) begin
            sw_ack_reg <= (sw_ack_reg & ~sel_mask) | (wb_dat_i & sel_mask);
        end
        // Unmapped addresses read as zero and writes there are dropped
        if (wb_hit & ~wb_we_i) begin
            if (wb_adr_i == `TXD_OFS_HEAD) begin
                wb_dat_o <= busy ? cur_reg : `TXD_RST_WORD;
            end else if (wb_adr_i == `TXD_OFS_ACK) begin
                wb_dat_o <= done_reg;
            end else if (wb_adr_i == `TXD_OFS_CTRL) begin
                wb_dat_o <= {31'h0000_0000, tdn_pend_reg};
            end else if (wb_adr_i == `TXD_OFS_STAT) begin
                wb_dat_o <= {pkt_rem_reg, 11'h000, chan_int_o, st_nown_reg, st_tdn_reg, st_qend_reg, busy};
            end else begin
                wb_dat_o <= `TXD_RST_WORD;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Descriptor walker and data mover
always @(posedge clk_i) begin
    if (rst_i) begin
        state_reg <= S_IDLE;
        cur_reg <= `TXD_RST_WORD;
        link_reg <= `TXD_RST_WORD;
        bptr_reg <= `TXD_RST_WORD;
        ofslen_reg <= `TXD_RST_WORD;
        flglen_reg <= `TXD_RST_WORD;
        widx_reg <= 2'h0;
        idx_reg <= 16'h0000;
        skip_reg <= 16'h0000;
        pkt_rem_reg <= 16'h0000;
        sop_addr_reg <= `TXD_RST_WORD;
        sop_w3_reg <= `TXD_RST_WORD;
        crc_sup_reg <= 1'b0;
        in_pkt_reg <= 1'b0;
        halt_after_reg <= 1'b0;
        cidx_reg <= 2'h0;
        done_reg <= `TXD_RST_WORD;
        tdn_pend_reg <= 1'b0;
        st_qend_reg <= 1'b0;
        st_tdn_reg <= 1'b0;
        st_nown_reg <= 1'b0;
        crc_init_reg <= 1'b0;
        mem_req_o <= 1'b0;
        mem_we_o <= 1'b0;
        mem_addr_o <= `TXD_RST_WORD;
        mem_wdata_o <= `TXD_RST_WORD;
        tx_data_o <= 8'h00;
        tx_valid_o <= 1'b0;
        tx_first_o <= 1'b0;
        tx_last_o <= 1'b0;
    end else if (ce_i) begin
        crc_init_reg <= 1'b0;
        // Teardown command; a request while idle completes at once
        if (wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == `TXD_OFS_CTRL) & wb_dat_i[`TXD_CTRL_TDN]) begin
            if (busy) begin
                tdn_pend_reg <= 1'b1;
            end else begin
                st_tdn_reg <= 1'b1;
            end
        end
        case (state_reg)
            S_IDLE: begin
                // Head write starts or restarts; ignored while a list is active
                if (wb_hit & wb_we_i & (wb_adr_i == `TXD_OFS_HEAD) & (wb_dat_i != `TXD_RST_WORD)) begin
                    cur_reg <= {wb_dat_i[31:2], 2'b00};
                    widx_reg <= 2'h0;
                    in_pkt_reg <= 1'b0;
                    st_qend_reg <= 1'b0;
                    st_nown_reg <= 1'b0;
                    st_tdn_reg <= 1'b0;
                    state_reg <= S_DRD;
                end
            end
            S_DRD: begin
                // Four word reads from the aligned base, gap cycle between them
                if (~mem_req_o & ~mem_ack_i) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b0;
                    mem_addr_o <= cur_reg + {28'h000_0000, widx_reg, 2'b00};
                end
                if (mem_req_o & mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    widx_reg <= widx_reg + 2'h1;
                    if (widx_reg == 2'h0) begin
                        link_reg <= mem_rdata_i;
                    end else if (widx_reg == 2'h1) begin
                        bptr_reg <= mem_rdata_i;
                    end else if (widx_reg == 2'h2) begin
                        ofslen_reg <= mem_rdata_i;
                    end else begin
                        flglen_reg <= mem_rdata_i;
                        idx_reg <= 16'h0000;
                        skip_reg <= 16'h0000;
                        if (~in_pkt_reg & tdn_pend_reg) begin
                            // Mark only this packet, touch nothing after it
                            mem_wdata_o <= (mem_rdata_i | (32'h1 << `TXD_F_TDN)) & ~(32'h1 << `TXD_F_OWN);
                            state_reg <= S_TDN;
                        end else if (~in_pkt_reg & ~(mem_rdata_i[`TXD_F_FIRST] & mem_rdata_i[`TXD_F_OWN])) begin
                            // Not a packet handed to us: stop rather than guess
                            st_nown_reg <= 1'b1;
                            state_reg <= S_IDLE;
                        end else begin
                            if (~in_pkt_reg) begin
                                in_pkt_reg <= 1'b1;
                                sop_addr_reg <= cur_reg;
                                sop_w3_reg <= mem_rdata_i;
                                crc_sup_reg <= mem_rdata_i[`TXD_F_CRCSUP];
                                pkt_rem_reg <= mem_rdata_i[15:0];
                                skip_reg <= ofslen_reg[31:16];
                                crc_init_reg <= 1'b1;
                            end
                            state_reg <= S_BRD;
                            if (ofslen_reg[15:0] == 16'h0000) begin
                                state_reg <= S_BOUT;
                            end
                        end
                    end
                end
            end
            S_BRD: begin
                // One word read per byte; the lane is picked from the byte address
                if (~mem_req_o & ~mem_ack_i) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b0;
                    mem_addr_o <= {byte_addr[31:2], 2'b00};
                end
                if (mem_req_o & mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    tx_data_o <= mem_rdata_i[{byte_addr[1:0], 3'b000} +: 8];
                    tx_valid_o <= 1'b1;
                    tx_first_o <= (idx_reg == 16'h0000) & (sop_addr_reg == cur_reg);
                    tx_last_o <= frag_end & flglen_reg[`TXD_F_LAST] & crc_sup_reg;
                    state_reg <= S_BOUT;
                end
            end
            S_BOUT: begin
                // Empty buffers arrive here with no byte pending and fall through
                if ((tx_valid_o & tx_ready_i) | (buf_len == 16'h0000)) begin
                    tx_valid_o <= 1'b0;
                    tx_first_o <= 1'b0;
                    tx_last_o <= 1'b0;
                    idx_reg <= idx_reg + 16'h0001;
                    if (tx_valid_o) begin
                        pkt_rem_reg <= pkt_rem_reg - 16'h0001;
                    end
                    if (~frag_end & (buf_len != 16'h0000)) begin
                        state_reg <= S_BRD;
                    end else if (flglen_reg[`TXD_F_LAST]) begin
                        cidx_reg <= 2'h0;
                        halt_after_reg <= (link_reg == `TXD_RST_WORD);
                        state_reg <= crc_sup_reg ? S_QEND : S_COUT;
                    end else if (link_reg == `TXD_RST_WORD) begin
                        // Null link read mid-packet: stop, software restarts
                        st_qend_reg <= 1'b1;
                        state_reg <= S_IDLE;
                    end else begin
                        cur_reg <= link_reg;
                        widx_reg <= 2'h0;
                        state_reg <= S_DRD;
                    end
                end
            end
            S_COUT: begin
                // Generated CRC, inverted, low byte first, outside the lengths
                if (~tx_valid_o) begin
                    tx_data_o <= ~crc_val[{cidx_reg, 3'b000} +: 8];
                    tx_valid_o <= 1'b1;
                    tx_last_o <= (cidx_reg == `TXD_CRC_BYTES);
                end else if (tx_ready_i) begin
                    tx_valid_o <= 1'b0;
                    tx_last_o <= 1'b0;
                    cidx_reg <= cidx_reg + 2'h1;
                    if (cidx_reg == `TXD_CRC_BYTES) begin
                        state_reg <= S_QEND;
                    end
                end
            end
            S_QEND: begin
                // Queue end on the last descriptor is written before ownership
                // returns, so software never sees a free packet without it
                if (~halt_after_reg) begin
                    state_reg <= S_OWN;
                end else if (~mem_req_o & ~mem_ack_i) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b1;
                    mem_addr_o <= cur_reg + {28'h000_0000, `TXD_W_FLGLEN};
                    mem_wdata_o <= (cur_reg == sop_addr_reg) ?
                        ((flglen_reg | (32'h1 << `TXD_F_QEND)) & ~(32'h1 << `TXD_F_OWN)) :
                        (flglen_reg | (32'h1 << `TXD_F_QEND));
                end else if (mem_req_o & mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    mem_we_o <= 1'b0;
                    if (cur_reg == sop_addr_reg) begin
                        done_reg <= sop_addr_reg;
                        in_pkt_reg <= 1'b0;
                        st_qend_reg <= 1'b1;
                        state_reg <= S_IDLE;
                    end else begin
                        state_reg <= S_OWN;
                    end
                end
            end
            S_OWN: begin
                // Ownership is returned on the first descriptor only
                if (~mem_req_o & ~mem_ack_i) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b1;
                    mem_addr_o <= sop_addr_reg + {28'h000_0000, `TXD_W_FLGLEN};
                    mem_wdata_o <= sop_w3_reg & ~(32'h1 << `TXD_F_OWN);
                end else if (mem_req_o & mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    mem_we_o <= 1'b0;
                    done_reg <= sop_addr_reg;
                    in_pkt_reg <= 1'b0;
                    if (halt_after_reg) begin
                        st_qend_reg <= 1'b1;
                        state_reg <= S_IDLE;
                    end else begin
                        cur_reg <= link_reg;
                        widx_reg <= 2'h0;
                        state_reg <= S_DRD;
                    end
                end
            end
            S_TDN: begin
                // Teardown write to the first unsent packet, then stop until a head write restarts
                if (~mem_req_o & ~mem_ack_i) begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= 1'b1;
                    mem_addr_o <= cur_reg + {28'h000_0000, `TXD_W_FLGLEN};
                end else if (mem_req_o & mem_ack_i) begin
                    mem_req_o <= 1'b0;
                    mem_we_o <= 1'b0;
                    done_reg <= cur_reg;
                    // A teardown command in this very cycle stays pending: set wins over clear
                    tdn_pend_reg <= wb_hit & wb_we_i & wb_sel_i[0] & (wb_adr_i == `TXD_OFS_CTRL) & wb_dat_i[`TXD_CTRL_TDN];
                    st_tdn_reg <= 1'b1;
                    state_reg <= S_IDLE;
                end
            end
            default: begin
                state_reg <= S_IDLE;
            end
        endcase
    end
end

endmodule // txd_engine

//--- testbench/tb.sv
// Bench for the engine: descriptor walks, restart, teardown and register access
`include "txd_defines.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got %0h exp %0h", $time, g, e); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic tx_ready_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF, dly = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, rd;
    wire [31:0] wb_dat_o, mem_addr_o, mem_wdata_o, mem_rdata_i;
    wire [7:0] tx_data_o;
    wire wb_ack_o, mem_req_o, mem_we_o, mem_ack_i, tx_valid_o, tx_first_o, tx_last_o, chan_int_o;
    int err_total = 0, checked = 0, cyc_cnt = 0;
    logic [9:0] cap[$], exp_q[$];
    logic [7:0] pkt[$];
    txd_engine txd_engine_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
        .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_first_o(tx_first_o), .tx_last_o(tx_last_o),
        .tx_ready_i(tx_ready_i), .chan_int_o(chan_int_o));
    txd_mem_model mem_inst (.clk_i(clk_i), .rst_i(rst_i), .dly_i(dly), .mem_req_i(mem_req_o),
        .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i),
        .mem_ack_o(mem_ack_i));
    ////////////////////////////////////////////////////////////////////////
    always #4 clk_i = ~clk_i;
    // Stalling MAC side captures {first, last, byte}; the timeout cuts a hang short
    always @(posedge clk_i) begin
        tx_ready_i <= ~tx_ready_i;
        if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) cap.push_back({tx_first_o, tx_last_o, tx_data_o});
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            err_total++;
            summarize();
        end
    end
    // Classic single cycle: hold until ack is sampled, then release for a cycle
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= adr; wb_dat_i <= dat;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 100) begin @(posedge clk_i); n++; end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        do begin wb_xfer(1'b0, `TXD_OFS_STAT, 32'h0); n++; end while (rd[0] !== 1'b0 && n < 500);
    endtask
    task automatic desc(input logic [31:0] a, link, bptr, input logic [15:0] ofs, len, flg, plen);
        mem_inst.mem[a[11:2]] = link;
        mem_inst.mem[a[11:2] + 10'h1] = bptr;
        mem_inst.mem[a[11:2] + 10'h2] = {ofs, len};
        mem_inst.mem[a[11:2] + 10'h3] = {flg, plen};
    endtask
    // Bytes at any address; kept ones join the expected frame
    task automatic fill(input logic [31:0] a, input int n, input logic [7:0] s, input bit keep);
        logic [31:0] p;
        for (int i = 0; i < n; i++) begin
            p = a + i;
            mem_inst.mem[p[11:2]][8*p[1:0] +: 8] = s + i[7:0];
            if (keep) pkt.push_back(s + i[7:0]);
        end
    endtask
    // Reflected CRC worked out here, sent inverted, low byte first
    task automatic close_frame(input bit gen);
        logic [31:0] c;
        int n;
        c = `TXD_CRC_INIT;
        foreach (pkt[i]) begin
            c ^= {24'h0, pkt[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ `TXD_CRC_POLY : c >> 1;
        end
        c = ~c;
        if (gen) for (int k = 0; k < 4; k++) pkt.push_back(c[8*k +: 8]);
        n = pkt.size();
        foreach (pkt[i]) exp_q.push_back({i == 0, i == n - 1, pkt[i]});
        pkt.delete();
    endtask
    task automatic check_stream;
        `CHK(cap.size(), exp_q.size())
        foreach (exp_q[i]) if (i < cap.size()) `CHK(cap[i], exp_q[i])
        cap.delete();
        exp_q.delete();
    endtask
    task automatic summarize;
        $display("errors %0d of %0d checks", err_total, checked);
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a <= 16; a += 4) begin wb_xfer(1'b0, a[7:0], 32'h0); `CHK(rd, 32'h0) end
        // Offset skip on an odd buffer, generated CRC, queue end
        desc(32'h100, 32'h0, 32'h203, 16'h000F, 16'h3, 16'hE000, 16'h3);
        fill(32'h203, 15, 8'hA0, 0);
        fill(32'h212, 3, 8'h11, 1);
        close_frame(1);
        wb_xfer(1'b1, `TXD_OFS_HEAD, 32'h100);
        wait_idle();
        check_stream();
        `CHK(mem_inst.mem[10'h43], 32'hD000_0003)
        `CHK(mem_inst.mem[10'h42], 32'h000F_0003)
        `CHK(rd[1], 1'b1)
        `CHK(chan_int_o, 1'b1)
        wb_xfer(1'b0, `TXD_OFS_ACK, 32'h0);
        `CHK(rd, 32'h100)
        wb_xfer(1'b1, `TXD_OFS_ACK, 32'h100);
        `CHK(chan_int_o, 1'b0)
        // Two fragments, supplied CRC, slow memory
        dly <= 4'h3;
        desc(32'h140, 32'h180, 32'h301, 16'h2, 16'h4, 16'hA400, 16'hA);
        desc(32'h180, 32'h0, 32'h340, 16'h5, 16'h6, 16'h4000, 16'h0);
        fill(32'h301, 2, 8'hE0, 0);
        fill(32'h303, 4, 8'h21, 1);
        fill(32'h340, 6, 8'h31, 1);
        close_frame(0);
        wb_xfer(1'b1, `TXD_OFS_HEAD, 32'h140);
        wait_idle();
        check_stream();
        `CHK(mem_inst.mem[10'h53], 32'h8400_000A)
        `CHK(mem_inst.mem[10'h63], 32'h5000_0000)
        `CHK(mem_inst.mem[10'h50], 32'h180)
        // Link patched after the null was read: no follow until restart
        desc(32'h1C0, 32'h0, 32'h360, 16'h0, 16'h1, 16'hE000, 16'h1);
        fill(32'h360, 1, 8'h55, 1);
        close_frame(1);
        mem_inst.mem[10'h60] = 32'h1C0;
        wait_idle();
        `CHK(cap.size(), 0)
        wb_xfer(1'b1, `TXD_OFS_HEAD, 32'h1C0);
        wait_idle();
        check_stream();
        wb_xfer(1'b0, `TXD_OFS_ACK, 32'h0);
        `CHK(rd, 32'h1C0)
        // Teardown before the first packet is fetched
        dly <= 4'h8;
        desc(32'h200, 32'h240, 32'h380, 16'h0, 16'h2, 16'hE000, 16'h2);
        desc(32'h240, 32'h0, 32'h390, 16'h0, 16'h2, 16'hE000, 16'h2);
        wb_xfer(1'b1, `TXD_OFS_HEAD, 32'h200);
        wb_xfer(1'b1, `TXD_OFS_CTRL, 32'h1);
        wait_idle();
        `CHK(cap.size(), 0)
        `CHK(mem_inst.mem[10'h83], 32'hC800_0002)
        `CHK(mem_inst.mem[10'h93], 32'hE000_0002)
        `CHK(rd[2], 1'b1)
        // Restart on a packet no longer owned: halts with no data sent
        wb_xfer(1'b1, `TXD_OFS_HEAD, 32'h200);
        wait_idle();
        `CHK(rd[3], 1'b1)
        `CHK(cap.size(), 0)
        summarize();
    end
endmodule // tb

//--- testbench/txd_engine_assertions.sv
// Concurrent checks on the transmit descriptor engine ports
module txd_engine_chk (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire mem_req_o,
    input wire mem_we_o,
    input wire [31:0] mem_addr_o,
    input wire [31:0] mem_wdata_o,
    input wire [31:0] mem_rdata_i,
    input wire mem_ack_i,
    input wire [7:0] tx_data_o,
    input wire tx_valid_o,
    input wire tx_first_o,
    input wire tx_last_o,
    input wire tx_ready_i,
    input wire chan_int_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    // Register bus answers exactly one cycle after a taken request
    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("register ack late");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("register ack too long");
    // Memory requests are word aligned and held until answered
    property p_mem_align;
        mem_req_o |-> mem_addr_o[1:0] == 2'b00;
    endproperty
    a_mem_align: assert property (p_mem_align) else $error("memory address unaligned");
    property p_mem_hold;
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o);
    endproperty
    a_mem_hold: assert property (p_mem_hold) else $error("memory request changed early");
    property p_mem_gap;
        mem_ack_i |=> !mem_req_o;
    endproperty
    a_mem_gap: assert property (p_mem_gap) else $error("memory request not dropped");
    // Byte stream: held while stalled, one idle cycle after each byte
    property p_tx_hold;
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("stream byte dropped while stalled");
    property p_tx_gap;
        tx_valid_o && tx_ready_i |=> !tx_valid_o;
    endproperty
    a_tx_gap: assert property (p_tx_gap) else $error("stream byte repeated");
    property p_first_valid;
        tx_first_o || tx_last_o |-> tx_valid_o;
    endproperty
    a_first_valid: assert property (p_first_valid) else $error("frame mark without data");
    c_frame: cover property (tx_first_o && tx_ready_i);
    c_write: cover property (mem_req_o && mem_we_o && mem_ack_i);
    c_int: cover property ($rose(chan_int_o));
endmodule // txd_engine_chk
bind txd_engine txd_engine_chk txd_engine_chk_inst (.*);

//--- testbench/txd_mem_model.sv
// System memory holding descriptors and packet bytes, with a programmable stall
module txd_mem_model (
    input wire clk_i,
    input wire rst_i,
    input wire [3:0] dly_i,
    input wire mem_req_i,
    input wire mem_we_i,
    input wire [31:0] mem_addr_i,
    input wire [31:0] mem_wdata_i,
    output logic [31:0] mem_rdata_o,
    output logic mem_ack_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:1023];
    logic [3:0] wait_q;
    // One access at a time; read data churns outside the answer cycle so stale data is never trusted
    always @(posedge clk_i) begin
        mem_ack_o <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        if (rst_i) begin
            wait_q <= 4'h0;
            mem_rdata_o <= 32'h0;
        end else if (mem_req_i && !mem_ack_o) begin
            if (wait_q >= dly_i) begin
                mem_ack_o <= 1'b1;
                wait_q <= 4'h0;
                mem_rdata_o <= mem[mem_addr_i[11:2]];
                if (mem_we_i) begin
                    mem[mem_addr_i[11:2]] <= mem_wdata_i;
                end
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule // txd_mem_model
